// [hdl/xmi_map.svh]
// Operation
// - each cycle has an address phase then a data strobe phase
// - read/write line high for reads, low for writes, held to next cycle
// - data strobe stays high through internal memory cycles
// - with hold request enabled, request sampled at end of data phase
// - while request low, bus stalls with all pins floated until high
// - acknowledge output driven low while the bus is floated
// - hold request function off after reset until enabled in control
// - low port carries low address then data in alternate function mode
// - high port carries upper address byte in alternate function mode
// - wait pin, when enabled, adds one cycle per active sample
// - wait in address phase stretches address strobe, else data strobe
// - strobe style bit gives latch enable, output enable, write enable
// - second strobe serves lower block when enabled, main strobe high
// - address strobe pin select enables the address strobe pin
// - pins toggle on internal cycles only if allowed, never the data strobes
// - segment save enable cleared: short interrupt frame
// - segment save enable set: full interrupt frame with code segment
// - page register remap bit exported to the page register logic
// - lower block address strobe stretch 0 to 3 cycles, reset 3
// - upper block address strobe stretch 0 to 3 cycles, reset 3
// - upper block data strobe stretch 0 to 7 cycles, reset 7
// - lower block data strobe stretch on the selected strobe, reset 7
// - data strobe stretch counts internal clock cycles
// - wait register bit 7 reads zero; bit 6 cleared selects watchdog
`ifndef XMI_MAP_SVH
`define XMI_MAP_SVH
// ==========================================
// register indices, byte address is index*4
`define XMI_IDX_CFG1 10'h0F5
`define XMI_IDX_CFG2 10'h0F6
`define XMI_IDX_SWR 10'h0FC
`define XMI_IDX_CTRL 10'h0F0
`define XMI_IDX_STAT 10'h0F1
// ==========================================
// reset values
`define XMI_RST_CFG1 8'h80
`define XMI_RST_CFG2 8'h1F
`define XMI_RST_SWR 8'h7F
`define XMI_RST_CTRL 8'h00
// ==========================================
// bus_config_one fields
`define XMI_B_MC 6
`define XMI_B_SECOND_STROBE_ENABLE 5
`define XMI_B_ASPIN 4
`define XMI_B_ITO 2
`define XMI_B_DRV 1
// bus_config_two fields
`define XMI_B_CSSAVE 6
`define XMI_B_REMAP 5
`define XMI_B_LAS 2
`define XMI_B_UAS 0
// strobe_wait_reg fields
`define XMI_B_TMODE 6
`define XMI_B_UDS 3
`define XMI_B_LDS 0
// control fields
`define XMI_B_HOLDEN 0
`define XMI_B_WAITEN 1
`define XMI_B_ALT 2
`define XMI_B_PROTDIS 3
// block select address bit
`define XMI_B_UPPER 21
`endif

// [hdl/xmi_pkg.sv]
package xmi_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_T1,
        ST_T2,
        ST_HOLD
    } xmi_state_t;
    typedef struct packed {
        logic as;
        logic as_oe;
        logic ds;
        logic ds2;
        logic rw;
        logic strobe_oe;
        logic [7:0] p0;
        logic p0_oe;
        logic [7:0] p1;
        logic p1_oe;
        logic ack_n;
        logic drive_strength_select;
    } xmi_pins_t;
    typedef struct packed {
        logic write;
        logic internal;
        logic [21:0] addr;
        logic [7:0] wdata;
    } xmi_req_t;
endpackage : xmi_pkg

// [hdl/xmi_top.sv]
// Local design decision: the APB slave port.
`timescale 1ns/1ns
`include "xmi_map.svh"
module xmi_top import xmi_pkg::*; (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // core access port
    input wire logic req_valid,
    input wire xmi_req_t req,
    output logic req_ready,
    output logic req_done,
    output logic [7:0] req_rdata,
    // external bus pins
    output xmi_pins_t pins,
    input wire logic [7:0] p0_in,
    input wire logic wait_n,
    input wire logic bus_hold_request_n,
    // control levels to core
    output logic code_segment_save_enable,
    output logic page_reg_remap,
    output logic watchdog_mode
);
    // ==========================================
    // helpers
    function automatic logic hit(input logic [11:0] a,
                                 input logic [9:0] idx);
        hit = (a[11:2] == idx);
    endfunction : hit

    function automatic logic [2:0] dstr(input logic up, input logic it,
                                        input logic [7:0] w);
        dstr = it ? 3'h0 : up ? w[`XMI_B_UDS +: 3] : w[`XMI_B_LDS +: 3];
    endfunction : dstr

    // ==========================================
    // registers
    logic [7:0] bus_config_one;
    logic [7:0] bus_config_two;
    logic [7:0] strobe_wait_reg;
    logic [7:0] ctrl;
    xmi_state_t st;
    xmi_state_t next_st;
    logic [2:0] cnt;
    logic [2:0] next_cnt;
    xmi_req_t cur;
    xmi_pins_t next_pins;
    logic apb_wr;
    logic [31:0] next_rd;
    logic mapped;
    logic mc;
    logic second_strobe_enable;
    logic hold_en;
    logic wait_en;
    logic alt;
    logic toggle;
    logic upper;
    logic wait_act;
    logic last_t2;
    logic hold_req;
    logic dsv;

    assign mc = bus_config_one[`XMI_B_MC];
    assign second_strobe_enable = bus_config_one[`XMI_B_SECOND_STROBE_ENABLE];
    assign hold_en = ctrl[`XMI_B_HOLDEN] & ctrl[`XMI_B_ALT];
    assign wait_en = ctrl[`XMI_B_WAITEN];
    assign alt = ctrl[`XMI_B_ALT];
    assign upper = cur.addr[`XMI_B_UPPER];
    assign toggle = ~cur.internal |
        (bus_config_one[`XMI_B_ITO] & ctrl[`XMI_B_PROTDIS]);
    assign wait_act = wait_en & ~wait_n;
    assign last_t2 = (st == ST_T2) & ~wait_act & (cnt == 3'h0);
    assign hold_req = hold_en & ~bus_hold_request_n;

    // ==========================================
    // apb slave
    assign apb_wr = psel & penable & pready & pwrite;
    assign mapped = hit(paddr, `XMI_IDX_CFG1) | hit(paddr, `XMI_IDX_CFG2) |
        hit(paddr, `XMI_IDX_SWR) | hit(paddr, `XMI_IDX_CTRL) |
        hit(paddr, `XMI_IDX_STAT);

    always_comb begin
        next_rd = 32'h0000_0000;
        if (hit(paddr, `XMI_IDX_CFG1)) begin
            next_rd[7:0] = bus_config_one;
        end
        if (hit(paddr, `XMI_IDX_CFG2)) begin
            next_rd[7:0] = bus_config_two;
        end
        if (hit(paddr, `XMI_IDX_SWR)) begin
            next_rd[7:0] = {1'b0, strobe_wait_reg[6:0]};
        end
        if (hit(paddr, `XMI_IDX_CTRL)) begin
            next_rd[7:0] = ctrl;
        end
        if (hit(paddr, `XMI_IDX_STAT)) begin
            next_rd[7:0] = {4'h0, ~pins.ack_n, req_ready, st};
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            if (psel & ~penable) begin
                prdata <= next_rd;
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            bus_config_one <= `XMI_RST_CFG1;
            bus_config_two <= `XMI_RST_CFG2;
            strobe_wait_reg <= `XMI_RST_SWR;
            ctrl <= `XMI_RST_CTRL;
        end else if (apb_wr) begin
            if (hit(paddr, `XMI_IDX_CFG1)) begin
                bus_config_one <= {bus_config_one[7], pwdata[6:1], 1'b0};
            end
            if (hit(paddr, `XMI_IDX_CFG2)) begin
                bus_config_two <= pwdata[7:0];
            end
            if (hit(paddr, `XMI_IDX_SWR)) begin
                strobe_wait_reg <= {1'b0, pwdata[6:0]};
            end
            if (hit(paddr, `XMI_IDX_CTRL)) begin
                ctrl <= {4'h0, pwdata[3:0]};
            end
        end
    end

    // ==========================================
    // level outputs to the core
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            code_segment_save_enable <= 1'b0;
            page_reg_remap <= 1'b0;
            watchdog_mode <= 1'b0;
        end else begin
            code_segment_save_enable <= bus_config_two[`XMI_B_CSSAVE];
            page_reg_remap <= bus_config_two[`XMI_B_REMAP];
            watchdog_mode <= ~strobe_wait_reg[`XMI_B_TMODE];
        end
    end

    // ==========================================
    // memory cycle sequencer
    always_comb begin
        next_st = st;
        next_cnt = cnt;
        case (st)
            ST_IDLE: begin
                if (hold_req) begin
                    next_st = ST_HOLD;
                end else if (req_valid) begin
                    next_st = ST_T1;
                    if (req.internal) begin
                        next_cnt = 3'h0;
                    end else if (req.addr[`XMI_B_UPPER]) begin
                        next_cnt = {1'b0, bus_config_two[`XMI_B_UAS +: 2]};
                    end else begin
                        next_cnt = {1'b0, bus_config_two[`XMI_B_LAS +: 2]};
                    end
                end
            end
            ST_T1: begin
                if (wait_act) begin
                    next_st = ST_T1;
                end else if (cnt != 3'h0) begin
                    next_cnt = cnt - 3'h1;
                end else begin
                    next_st = ST_T2;
                    next_cnt = dstr(upper, cur.internal, strobe_wait_reg);
                end
            end
            ST_T2: begin
                if (wait_act) begin
                    next_st = ST_T2;
                end else if (cnt != 3'h0) begin
                    next_cnt = cnt - 3'h1;
                end else if (hold_req) begin
                    next_st = ST_HOLD;
                end else begin
                    next_st = ST_IDLE;
                end
            end
            ST_HOLD: begin
                if (bus_hold_request_n) begin
                    next_st = ST_IDLE;
                end
            end
            default: begin
                next_st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st <= ST_IDLE;
            cnt <= 3'h0;
            req_ready <= 1'b0;
        end else begin
            st <= next_st;
            cnt <= next_cnt;
            req_ready <= (next_st == ST_IDLE) & ~(st == ST_IDLE & req_valid);
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cur <= '0;
        end else if (st == ST_IDLE && !hold_req && req_valid) begin
            cur <= req;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            req_done <= 1'b0;
            req_rdata <= 8'h00;
        end else begin
            req_done <= last_t2;
            if (last_t2 && !cur.write && !cur.internal) begin
                req_rdata <= p0_in;
            end
        end
    end

    // ==========================================
    // pin drive
    always_comb begin
        next_pins = pins;
        dsv = 1'b1;
        next_pins.ack_n = 1'b1;
        next_pins.as_oe = alt & bus_config_one[`XMI_B_ASPIN];
        next_pins.strobe_oe = alt;
        next_pins.p1_oe = alt;
        next_pins.drive_strength_select = bus_config_one[`XMI_B_DRV];
        next_pins.as = ~mc;
        next_pins.ds = 1'b1;
        next_pins.ds2 = 1'b1;
        case (st)
            ST_IDLE: begin
                if (mc) begin
                    next_pins.rw = 1'b1;
                end
            end
            ST_T1: begin
                if (toggle) begin
                    next_pins.as = mc;
                    next_pins.p0 = cur.addr[7:0];
                    next_pins.p0_oe = alt;
                    next_pins.p1 = cur.addr[15:8];
                    next_pins.rw = mc | ~cur.write;
                end
            end
            ST_T2: begin
                dsv = cur.internal;
                if (toggle) begin
                    next_pins.p0_oe = alt & cur.write;
                    if (cur.write) begin
                        next_pins.p0 = cur.wdata;
                    end
                    if (mc) begin
                        next_pins.rw = cur.write ? dsv : 1'b1;
                    end
                end
                if (second_strobe_enable && !upper) begin
                    next_pins.ds2 = dsv | (mc & cur.write);
                end else begin
                    next_pins.ds = dsv | (mc & cur.write);
                end
            end
            ST_HOLD: begin
                next_pins.as_oe = 1'b0;
                next_pins.strobe_oe = 1'b0;
                next_pins.p0_oe = 1'b0;
                next_pins.p1_oe = 1'b0;
                next_pins.ack_n = 1'b0;
            end
            default: begin
                next_pins.ack_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pins <= '{as: 1'b1, as_oe: 1'b0, ds: 1'b1, ds2: 1'b1, rw: 1'b1,
                      strobe_oe: 1'b0, p0: 8'hFF, p0_oe: 1'b0, p1: 8'hFF,
                      p1_oe: 1'b0, ack_n: 1'b1,
                      drive_strength_select: 1'b0};
        end else begin
            pins <= next_pins;
        end
    end

    // ==========================================
    // checks
    sequence s_t2_end;
        last_t2 && hold_req;
    endsequence

    sequence s_floated;
        !pins.ack_n && !pins.p0_oe && !pins.p1_oe && !pins.strobe_oe;
    endsequence

    property p_hold_enter;
        @(posedge clock) disable iff (!nrst)
        s_t2_end |=> st == ST_HOLD ##1 s_floated;
    endproperty
    a_hold_enter: assert property (p_hold_enter)
        else $error("hold not entered at end of data phase");

    property p_hold_float;
        @(posedge clock) disable iff (!nrst)
        !pins.ack_n |-> !pins.as_oe && !pins.p0_oe && !pins.strobe_oe;
    endproperty
    a_hold_float: assert property (p_hold_float)
        else $error("pins driven while acknowledge low");

    property p_hold_leave;
        @(posedge clock) disable iff (!nrst)
        st == ST_HOLD && bus_hold_request_n |=> st == ST_IDLE;
    endproperty
    a_hold_leave: assert property (p_hold_leave)
        else $error("hold kept after request released");

    property p_hold_off;
        @(posedge clock) disable iff (!nrst)
        !hold_en && st != ST_HOLD |=> st != ST_HOLD;
    endproperty
    a_hold_off: assert property (p_hold_off)
        else $error("hold entered while disabled");

    property p_rw_level;
        @(posedge clock) disable iff (!nrst)
        st == ST_T1 && toggle && !mc |=> pins.rw == !cur.write;
    endproperty
    a_rw_level: assert property (p_rw_level)
        else $error("read/write level wrong");

    property p_int_ds;
        @(posedge clock) disable iff (!nrst)
        st == ST_T2 && cur.internal |=> pins.ds && pins.ds2;
    endproperty
    a_int_ds: assert property (p_int_ds)
        else $error("strobe low on internal cycle");

    property p_addr_out;
        @(posedge clock) disable iff (!nrst)
        st == ST_T1 && toggle |=>
            pins.p0 == cur.addr[7:0] && pins.p1 == cur.addr[15:8];
    endproperty
    a_addr_out: assert property (p_addr_out)
        else $error("address not on ports");

    property p_wait_hold;
        @(posedge clock) disable iff (!nrst)
        st == ST_T1 && wait_act |=> st == ST_T1 && cnt == $past(cnt);
    endproperty
    a_wait_hold: assert property (p_wait_hold)
        else $error("wait did not stretch address phase");

    property p_ast_load;
        @(posedge clock) disable iff (!nrst)
        st == ST_IDLE && !hold_req && req_valid && !req.internal &&
            !req.addr[21] |=> cnt == {1'b0, bus_config_two[3:2]};
    endproperty
    a_ast_load: assert property (p_ast_load)
        else $error("lower address stretch not loaded");

    property p_dst_load;
        @(posedge clock) disable iff (!nrst)
        st == ST_T1 && !wait_act && cnt == 3'h0 && !cur.internal &&
            upper |=> st == ST_T2 && cnt == strobe_wait_reg[5:3];
    endproperty
    a_dst_load: assert property (p_dst_load)
        else $error("upper data stretch not loaded");

    property p_ds2_route;
        @(posedge clock) disable iff (!nrst)
        st == ST_T2 && second_strobe_enable && !upper && !cur.internal |=> pins.ds;
    endproperty
    a_ds2_route: assert property (p_ds2_route)
        else $error("main strobe active on lower block");
endmodule : xmi_top

// [verif/ext_memory_bus_interface_test.sv]
`timescale 1ns/1ns
`include "xmi_map.svh"
module ext_memory_bus_interface_test import xmi_pkg::*;;
    logic clock, nrst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic req_valid, req_ready, req_done, wait_n, hreq_n;
    logic cs_save, remap, wdog, mc, hold_on, mon;
    xmi_req_t req;
    logic [7:0] req_rdata, p0_in, q;
    xmi_pins_t pins;
    logic [3:0] wait_len;
    int bad_count, cmp_count, cyc, n, n_as, n_ds, n_ds2, n_rw, k;
    logic rwd, e;
    xmi_top dut_u (.clock(clock), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .req_done(req_done), .req_rdata(req_rdata), .pins(pins),
        .p0_in(p0_in), .wait_n(wait_n), .bus_hold_request_n(hreq_n),
        .code_segment_save_enable(cs_save), .page_reg_remap(remap),
        .watchdog_mode(wdog));
    xmi_ext_model model_u (.clock(clock), .pins(pins), .p0_in(p0_in),
        .wait_n(wait_n), .bus_hold_request_n(hreq_n), .style(mc),
        .wait_len(wait_len), .hold_on(hold_on));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // ==========================================
    // strobe activity counters
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            end_sim();
        end
        if (mon) begin
            n_as += (mc ? pins.as : !pins.as);
            n_ds += !pins.ds;
            n_ds2 += !pins.ds2;
            n_rw += !pins.rw;
        end
    end
    // ==========================================
    // tasks
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [9:0] idx,
        input logic [7:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        q = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [9:0] idx, input logic [7:0] x);
        apb(1'b0, idx, 8'h00);
        chk(q, x);
        chk(e, 1'b0);
    endtask : rd
    task automatic acc(input logic w, input logic it, input logic [21:0] a,
        input logic [7:0] d);
        @(posedge clock);
        req_valid <= 1'b1;
        req <= '{w, it, a, d};
        do @(posedge clock); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        mon <= 1'b1;
        {n, n_as, n_ds, n_ds2, n_rw} = '0;
        do begin
            @(posedge clock);
            n++;
        end while (req_done !== 1'b1 && n < 300);
        rwd = pins.rw;
        repeat (2) @(posedge clock);
        mon <= 1'b0;
    endtask : acc
    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim
    // ==========================================
    // test sequence
    initial begin
        {nrst, psel, penable, pwrite, req_valid, mc, hold_on, mon} = '0;
        {paddr, pwdata, req, wait_len} = '0;
        repeat (12) @(posedge clock);
        nrst <= 1'b1;
        rd(`XMI_IDX_CFG1, 8'h80);
        rd(`XMI_IDX_CFG2, 8'h1F);
        rd(`XMI_IDX_SWR, 8'h7F);
        rd(`XMI_IDX_CTRL, 8'h00);
        rd(`XMI_IDX_STAT, 8'h04);
        chk(wdog, 1'b0);
        apb(1'b0, 10'h000, 8'h00);
        chk({e, q}, 9'h100);
        apb(1'b1, `XMI_IDX_SWR, 8'hBF);
        rd(`XMI_IDX_SWR, 8'h3F);
        chk(wdog, 1'b1);
        apb(1'b1, `XMI_IDX_SWR, 8'h7F);
        apb(1'b1, `XMI_IDX_CFG2, 8'h7F);
        rd(`XMI_IDX_CFG2, 8'h7F);
        chk({cs_save, remap}, 2'b11);
        apb(1'b1, `XMI_IDX_CFG2, 8'h1F);
        apb(1'b1, `XMI_IDX_CFG1, 8'h7F);
        rd(`XMI_IDX_CFG1, 8'hFE);
        chk({cs_save, remap}, 2'b00);
        chk(pins.drive_strength_select, 1'b1);
        apb(1'b1, `XMI_IDX_CFG1, 8'h80);
        apb(1'b1, `XMI_IDX_CTRL, 8'h04);
        repeat (2) @(posedge clock);
        chk(pins.as_oe, 1'b0);
        apb(1'b1, `XMI_IDX_CFG1, 8'h90);
        repeat (2) @(posedge clock);
        chk({pins.as_oe, pins.p1_oe, pins.strobe_oe}, 3'b111);
        $display("test regs done");
        acc(1'b1, 1'b0, 22'h201234, 8'hA5);
        chk(n, 13);
        chk({n_as, n_ds, n_ds2}, {32'd4, 32'd8, 32'd0});
        chk(rwd, 1'b0);
        chk(model_u.mem[16'h1234], 8'hA5);
        acc(1'b0, 1'b0, 22'h201234, 8'h00);
        chk({rwd, req_rdata}, 9'h1A5);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, `XMI_IDX_CFG2, {4'h1, i[1:0], 2'(3 - i)});
            apb(1'b1, `XMI_IDX_SWR, {2'b01, 3'(7 - 2 * i), 3'(2 * i)});
            acc(1'b1, 1'b0, 22'h000042, 8'h3C);
            chk(n, 32'(3 + 3 * i));
            chk(n_as, 32'(1 + i));
            chk(n_ds, 32'(1 + 2 * i));
            acc(1'b1, 1'b0, 22'h200042, 8'hC3);
            chk(n, 32'(13 - 3 * i));
            chk(n_as, 32'(4 - i));
            chk(n_ds, 32'(8 - 2 * i));
        end
        acc(1'b1, 1'b1, 22'h000010, 8'h11);
        chk({n, n_as, n_ds}, {32'd3, 32'd0, 32'd0});
        apb(1'b1, `XMI_IDX_CTRL, 8'h0C);
        apb(1'b1, `XMI_IDX_CFG1, 8'h94);
        acc(1'b1, 1'b1, 22'h000010, 8'h11);
        chk({n_as, n_ds, n_ds2}, {32'd1, 32'd0, 32'd0});
        apb(1'b1, `XMI_IDX_CFG1, 8'h90);
        apb(1'b1, `XMI_IDX_CFG2, 8'h1F);
        apb(1'b1, `XMI_IDX_SWR, 8'h7F);
        $display("test timing done");
        apb(1'b1, `XMI_IDX_CTRL, 8'h06);
        wait_len <= 4'h3;
        acc(1'b1, 1'b0, 22'h201000, 8'h77);
        chk({n, n_as, n_ds}, {32'd16, 32'd7, 32'd8});
        wait_len <= 4'h0;
        apb(1'b1, `XMI_IDX_CFG1, 8'hF0);
        mc <= 1'b1;
        acc(1'b1, 1'b0, 22'h000055, 8'h5A);
        chk({n_as, n_ds}, {32'd4, 32'd0});
        chk({n_ds2, n_rw}, {32'd0, 32'd8});
        acc(1'b0, 1'b0, 22'h000055, 8'h00);
        chk({n_ds, n_ds2}, {32'd0, 32'd8});
        chk(n_rw, 32'd0);
        chk(req_rdata, 8'h5A);
        acc(1'b0, 1'b0, 22'h201234, 8'h00);
        chk({n_ds, n_ds2, req_rdata}, {32'd8, 32'd0, 8'hA5});
        apb(1'b1, `XMI_IDX_CFG1, 8'h90);
        mc <= 1'b0;
        $display("test wait and style done");
        apb(1'b1, `XMI_IDX_CTRL, 8'h04);
        hold_on <= 1'b1;
        repeat (10) @(posedge clock);
        chk({pins.ack_n, req_ready}, 2'b11);
        apb(1'b1, `XMI_IDX_CTRL, 8'h05);
        for (k = 0; k < 10 && pins.ack_n !== 1'b0; k++) @(posedge clock);
        chk(pins.ack_n, 1'b0);
        chk({pins.as_oe, pins.strobe_oe}, 2'b00);
        chk({pins.p0_oe, pins.p1_oe}, 2'b00);
        chk(req_ready, 1'b0);
        hold_on <= 1'b0;
        for (k = 0; k < 10 && pins.ack_n !== 1'b1; k++) @(posedge clock);
        repeat (2) @(posedge clock);
        chk({pins.ack_n, pins.strobe_oe, pins.p1_oe}, 3'b111);
        acc(1'b0, 1'b0, 22'h201234, 8'h00);
        chk({n, req_rdata}, {32'd13, 8'hA5});
        fork
            acc(1'b1, 1'b0, 22'h201234, 8'hA5);
            begin
                repeat (4) @(posedge clock);
                hold_on <= 1'b1;
            end
        join
        chk({n, pins.ack_n}, {32'd13, 1'b0});
        rd(`XMI_IDX_STAT, 8'h0B);
        hold_on <= 1'b0;
        repeat (4) @(posedge clock);
        chk({pins.ack_n, req_ready}, 2'b11);
        $display("test hold done");
        end_sim();
    end
endmodule : ext_memory_bus_interface_test

// [verif/xmi_ext_model.sv]
`timescale 1ns/1ns
// ==========================================
// external memory and bus master model
module xmi_ext_model import xmi_pkg::*; (
    // clock
    input wire logic clock,
    // bus side
    input wire xmi_pins_t pins,
    output logic [7:0] p0_in,
    output logic wait_n,
    output logic bus_hold_request_n,
    // bench control
    input wire logic style,
    input wire logic [3:0] wait_len,
    input wire logic hold_on
);
    logic [7:0] mem [0:65535];
    logic [15:0] addr = 16'h0000;
    logic [7:0] wd = 8'h00;
    logic [7:0] last = 8'h00;
    logic [3:0] wcnt = 4'h0;
    logic as_prev = 1'b0;
    logic we_prev = 1'b0;
    logic as_act;
    logic we;
    logic oe;
    assign as_act = style ? pins.as : !pins.as;
    assign we = !pins.rw && (style || !(pins.ds && pins.ds2));
    assign oe = !(pins.ds && pins.ds2) && (style || pins.rw);
    // released bus shows the inverse of the last value
    assign p0_in = oe ? mem[addr] : ~last;
    assign wait_n = (wcnt == 4'h0);
    assign bus_hold_request_n = !hold_on;
    always @(posedge clock) begin
        last <= p0_in;
        as_prev <= as_act;
        we_prev <= we;
        if (as_act && pins.p0_oe) begin
            addr <= {pins.p1, pins.p0};
        end
        if (we) begin
            wd <= pins.p0;
        end
        if (we_prev && !we) begin
            mem[addr] <= wd;
        end
        if (as_act && !as_prev) begin
            wcnt <= wait_len;
        end else if (wcnt != 4'h0) begin
            wcnt <= wcnt - 4'h1;
        end
    end
endmodule : xmi_ext_model
